// ---- tmz_cfg.svh ----
`ifndef TMZ_CFG_SVH
`define TMZ_CFG_SVH
// ****************************************
// File addresses seen by the core
// ****************************************
`define TMZ_ADDR_TIMER   5'h01
`define TMZ_ADDR_CMP_A   5'h07
`define TMZ_ADDR_CMP_B   5'h08
// ****************************************
// Field positions
// ****************************************
`define TMZ_OPT_CS       5
`define TMZ_OPT_SE       4
`define TMZ_OPT_ASSIGN   3
`define TMZ_CMP_OUT      7
`define TMZ_CMP_OEN      6
`define TMZ_CMP_POL      5
`define TMZ_CMP_SRC      4
// ****************************************
// Reset values and timing counts
// ****************************************
`define TMZ_OPT_RST      8'hFF
`define TMZ_CMP_RST      7'h7F
`define TMZ_TRIS_RST     6'h3F
`define TMZ_INHIBIT_CYC  2'h2
`endif

// ---- tmz_pkg.sv ----
`default_nettype none
package tmz_pkg;
  // Oscillator phases of one instruction cycle, one-hot
  typedef enum logic [3:0] {
    TMZ_PHASE_ONE   = 4'b0001,
    TMZ_PHASE_TWO   = 4'b0010,
    TMZ_PHASE_THREE = 4'b0100,
    TMZ_PHASE_FOUR  = 4'b1000
  } tmz_phase_type;
endpackage
`default_nettype wire

// ---- tmz_timer0.sv ----
// What this block does
// - Source select clear: timer counts once per instruction cycle without prescaler.
// - A timer write stops counting for the next two instruction cycles.
// - Source select, comparator source and pin disable all set: count pin edges.
// - Edge select clear counts rising edges, set counts falling edges.
// - Source select set, comparator source clear: count comparator internally.
// - Pin disable clear with pin source: drive comparator onto pin, still count pin.
// - Prescaler serves timer when assign bit clear, watchdog when set.
// - Timer prescale ratios run from 1:2 to 1:256 in powers of two.
// - Prescaler is hidden from software, changed only by clearing and counting.
// - Any timer write clears the prescaler while it serves the timer.
// - Watchdog clear instruction clears the prescaler while it serves the watchdog.
// - Every reset leaves the prescaler at zero.
// - Prescaler output is sampled in phases two and four.
// - Prescaler divides the count input ahead of synchronisation.
// - Timer increments two to four oscillator periods after the input edge, three to five when prescaled.
// - Prescaler is 8 bits, timer count register is 8 bits read/write.
// - Source select set overrides the pin direction: the pin is an input unless the comparator is driven onto it.
`timescale 1ns/1ns
`default_nettype none
`include "tmz_cfg.svh"

module tmz_timer0
  import tmz_pkg::*;
#(
  parameter int unsigned TRIS_BIT = 2
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Core file access
  input  wire logic       i_file_wr,
  input  wire logic [4:0] i_file_addr,
  input  wire logic [7:0] i_file_wdata,
  input  wire logic [4:0] i_file_rd_addr,
  output var  logic [7:0] o_file_rdata,
  // Special instructions
  input  wire logic       i_option_wr,
  input  wire logic [7:0] i_option_data,
  input  wire logic       i_tris_wr,
  input  wire logic [5:0] i_tris_data,
  input  wire logic       i_dog_clear_instr,
  // Watchdog side
  input  wire logic       i_dog_overflow,
  output var  logic       o_dog_tick,
  // Count sources and pin
  input  wire logic       i_cmp_out,
  input  wire logic       i_ext_count_pin,
  input  wire logic       i_port_bit,
  output var  logic       o_ext_count_pin,
  output var  logic       o_ext_count_pin_oe_n
);

  // ****************************************
  // State
  // ****************************************
  tmz_phase_type phase_r;
  tmz_phase_type phase_nxt;
  logic [7:0] timer_count_r;
  logic [7:0] timer_count_nxt;
  logic [7:0] prescaler_r;
  logic [7:0] prescaler_nxt;
  logic [7:0] option_r;
  logic [6:0] cmp_ctrl_r;
  logic [5:0] tris_r;
  logic [1:0] inhibit_r;
  logic [1:0] inhibit_nxt;
  logic       in_r;
  logic       in_d_r;
  logic       samp_r;
  logic       samp_d_r;

  // ****************************************
  // Decode of configuration
  // ****************************************
  wire logic       count_source_select = option_r[`TMZ_OPT_CS];
  wire logic       count_edge_select   = option_r[`TMZ_OPT_SE];
  wire logic       scaler_assign       = option_r[`TMZ_OPT_ASSIGN];
  wire logic [2:0] scale_ratio         = option_r[2:0];
  wire logic       cmp_count_source    = cmp_ctrl_r[`TMZ_CMP_SRC];
  wire logic       cmp_pin_output_disable = cmp_ctrl_r[`TMZ_CMP_OEN];
  wire logic       to_timer            = ~scaler_assign;
  wire logic       phase_four          = (phase_r == TMZ_PHASE_FOUR);
  wire logic       sample_strobe       = (phase_r == TMZ_PHASE_TWO) | phase_four;
  wire logic       timer_wr = i_file_wr & (i_file_addr == `TMZ_ADDR_TIMER);
  wire logic       cmp_wr   = i_file_wr & ((i_file_addr == `TMZ_ADDR_CMP_A) |
                                           (i_file_addr == `TMZ_ADDR_CMP_B));

  // Low bits [n:0] set for timer ratio 2^(n+1), [n-1:0] for watchdog 2^n
  wire logic [7:0] timer_mask = ~(8'hFE << scale_ratio);
  wire logic [7:0] dog_mask   = ~(8'hFF << scale_ratio);
  wire logic       timer_carry = &(prescaler_r | ~timer_mask);
  wire logic       dog_carry   = &(prescaler_r | ~dog_mask);

  // ****************************************
  // Count input selection
  // ****************************************
  // Comparator level after the polarity bit
  wire logic cmp_level = cmp_ctrl_r[`TMZ_CMP_POL] ? i_cmp_out : ~i_cmp_out;
  // Pin source reads the pad even while we drive it, so comparator changes loop back
  wire logic count_src = cmp_count_source ? i_ext_count_pin : cmp_level;
  // Invert for falling-edge counting so one rising detector serves both
  wire logic count_lvl = count_src ^ count_edge_select;
  wire logic count_rise = count_source_select & in_r & ~in_d_r;

  // ****************************************
  // Prescaler: one shared 8-bit divider, no software path
  // ****************************************
  // Timer-mode prescaling pauses with the write inhibit, so a write always costs two whole cycles
  wire logic pres_inc = to_timer ? (count_source_select ? count_rise : (phase_four & (inhibit_r == 2'h0)))
                                 : i_dog_overflow;
  wire logic pres_clr = (timer_wr & to_timer) |
                        (i_dog_clear_instr & scaler_assign);
  // Unscaled counting samples the raw edge level directly
  wire logic pres_out = to_timer ? prescaler_r[scale_ratio] : in_r;

  always_comb begin
    prescaler_nxt = prescaler_r;
    if (pres_clr) begin
      prescaler_nxt = 8'h00;
    end else if (pres_inc) begin
      prescaler_nxt = prescaler_r + 8'h01;
    end
  end

  // ****************************************
  // Timer increment sources
  // ****************************************
  // External path: two-phase sample then edge, giving a bounded latency
  wire logic ext_tick = count_source_select & samp_r & ~samp_d_r;
  wire logic int_tick = ~count_source_select & phase_four &
                        (scaler_assign | timer_carry);
  wire logic inc_ok   = (inhibit_r == 2'h0);
  wire logic tick     = (ext_tick | int_tick) & inc_ok;

  // Write wins over a same-cycle increment
  always_comb begin
    timer_count_nxt = timer_count_r;
    if (timer_wr) begin
      timer_count_nxt = i_file_wdata;
    end else if (tick) begin
      timer_count_nxt = timer_count_r + 8'h01;
    end
  end

  // Inhibit counts down whole instruction cycles after a write
  always_comb begin
    inhibit_nxt = inhibit_r;
    if (timer_wr) begin
      inhibit_nxt = `TMZ_INHIBIT_CYC;
    end else if (phase_four && !inc_ok) begin
      inhibit_nxt = inhibit_r - 2'h1;
    end
  end

  // Phase sequencer
  always_comb begin
    case (phase_r)
      TMZ_PHASE_ONE:   phase_nxt = TMZ_PHASE_TWO;
      TMZ_PHASE_TWO:   phase_nxt = TMZ_PHASE_THREE;
      TMZ_PHASE_THREE: phase_nxt = TMZ_PHASE_FOUR;
      TMZ_PHASE_FOUR:  phase_nxt = TMZ_PHASE_ONE;
      default:         phase_nxt = TMZ_PHASE_ONE;
    endcase
  end

  // ****************************************
  // Pin control and read data
  // ****************************************
  wire logic pin_drive = count_source_select & cmp_count_source & ~cmp_pin_output_disable;
  // Source select takes the pin from the direction latch
  wire logic oe_n_nxt  = count_source_select ? ~pin_drive : tris_r[TRIS_BIT];
  wire logic pin_nxt   = count_source_select ? cmp_level : i_port_bit;
  wire logic dog_nxt   = i_dog_overflow & (to_timer | dog_carry);
  wire logic rd_timer  = (i_file_rd_addr == `TMZ_ADDR_TIMER);
  wire logic rd_cmp    = (i_file_rd_addr == `TMZ_ADDR_CMP_A) |
                         (i_file_rd_addr == `TMZ_ADDR_CMP_B);
  wire logic [7:0] rd_nxt = rd_timer ? timer_count_r :
                            rd_cmp   ? {i_cmp_out, cmp_ctrl_r} : 8'h00;

  // ****************************************
  // Registers
  // ****************************************
  // Counting state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      phase_r       <= TMZ_PHASE_ONE;
      timer_count_r <= 8'h00;
      prescaler_r   <= 8'h00;
      inhibit_r     <= 2'h0;
    end else begin
      phase_r       <= phase_nxt;
      timer_count_r <= timer_count_nxt;
      prescaler_r   <= prescaler_nxt;
      inhibit_r     <= inhibit_nxt;
    end
  end

  // Input edge and phase sampling
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      // Idle at the counted level of the reset setup (falling edges, low pin): no false edge
      in_r     <= 1'b1;
      in_d_r   <= 1'b1;
      samp_r   <= 1'b1;
      samp_d_r <= 1'b1;
    end else begin
      in_r     <= count_lvl;
      in_d_r   <= in_r;
      samp_d_r <= samp_r;
      if (sample_strobe) begin
        samp_r <= pres_out;
      end
    end
  end

  // Configuration written by the core
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      option_r   <= `TMZ_OPT_RST;
      cmp_ctrl_r <= `TMZ_CMP_RST;
      tris_r     <= `TMZ_TRIS_RST;
    end else begin
      if (i_option_wr) option_r <= i_option_data;
      if (cmp_wr)      cmp_ctrl_r <= i_file_wdata[6:0];
      if (i_tris_wr)   tris_r <= i_tris_data;
    end
  end

  // Registered outputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_file_rdata         <= 8'h00;
      o_dog_tick           <= 1'b0;
      o_ext_count_pin      <= 1'b0;
      o_ext_count_pin_oe_n <= 1'b1;
    end else begin
      o_file_rdata         <= rd_nxt;
      o_dog_tick           <= dog_nxt;
      o_ext_count_pin      <= pin_nxt;
      o_ext_count_pin_oe_n <= oe_n_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Unscaled timer mode steps by one per instruction cycle
  chk_timer_mode_step: assert property (
    (~count_source_select & scaler_assign & phase_four & inc_ok & ~timer_wr)
      |=> timer_count_r == $past(timer_count_r) + 8'h01)
    else $error("timer did not step in unscaled timer mode");

  // No increment for two instruction cycles after a write
  chk_write_inhibit: assert property (
    timer_wr ##1 (~timer_wr)[*8] |-> timer_count_r == $past(timer_count_r, 7))
    else $error("timer moved during write inhibit");

  // Pin source feeds the edge detector
  chk_pin_source: assert property (
    (cmp_count_source & ~count_edge_select) |=> in_r == $past(i_ext_count_pin))
    else $error("pin not selected as count source");

  // Falling select inverts the sampled level
  chk_edge_select: assert property (
    (cmp_count_source & count_edge_select) |=> in_r == !$past(i_ext_count_pin))
    else $error("edge select not applied");

  // Comparator internal path ignores the pin
  chk_cmp_internal: assert property (
    (~cmp_count_source & cmp_ctrl_r[`TMZ_CMP_POL] & ~count_edge_select)
      |=> in_r == $past(i_cmp_out))
    else $error("comparator path not selected");

  // Comparator driven onto the pin
  chk_pin_drive: assert property (
    $past(pin_drive) |-> (~o_ext_count_pin_oe_n & o_ext_count_pin == $past(cmp_level)))
    else $error("comparator not driven onto pin");

  // Pin is an input when counting externally without drive
  chk_tris_override: assert property (
    $past(count_source_select & ~pin_drive) |-> o_ext_count_pin_oe_n)
    else $error("pin direction not overridden");

  // Timer write clears a timer-assigned prescaler
  chk_scaler_clear: assert property (
    (timer_wr & to_timer) |=> prescaler_r == 8'h00)
    else $error("prescaler not cleared by timer write");

  // Watchdog clear clears a watchdog-assigned prescaler
  chk_dog_clear: assert property (
    (i_dog_clear_instr & scaler_assign) |=> prescaler_r == 8'h00)
    else $error("prescaler not cleared by watchdog clear");

  // Timer wraps to zero
  chk_timer_wrap: assert property (
    (timer_count_r == 8'hFF & tick & ~timer_wr) |=> timer_count_r == 8'h00)
    else $error("timer did not wrap");

  // External edge reaches the timer within seven oscillator periods
  chk_ext_latency: assert property (
    (count_source_select & scaler_assign & inc_ok & ~in_r & count_lvl & ~timer_wr)
      ##1 (count_source_select & ~timer_wr & inc_ok)[*7]
      |-> timer_count_r != $past(timer_count_r, 7))
    else $error("external edge not counted in time");

  // Scaled timer mode steps only on a full prescaler carry
  chk_ratio_hold: assert property (
    (~count_source_select & to_timer & ~timer_wr & ((prescaler_r & timer_mask) != timer_mask))
      |=> timer_count_r == $past(timer_count_r))
    else $error("timer stepped without prescaler carry");

  // A timer-assigned prescaler leaves the watchdog unscaled
  chk_dog_pass: assert property (
    (to_timer & i_dog_overflow) |=> o_dog_tick)
    else $error("watchdog tick lost while prescaler serves timer");

  // The count input is sampled only in phases two and four
  chk_sample_phase: assert property (
    ~sample_strobe |=> samp_r == $past(samp_r))
    else $error("count input sampled outside phases two and four");

  // The prescaler leaves reset at zero
  chk_reset_zero: assert property (
    $past(i_rst) |-> prescaler_r == 8'h00)
    else $error("prescaler not zero after reset");

  cov_timer_scaled: cover property (~count_source_select & to_timer & tick);
  cov_ratio_max:    cover property (~count_source_select & to_timer & (scale_ratio == 3'h7) & tick);
  cov_ext_count:    cover property (count_source_select & cmp_count_source & tick);
  cov_pin_drive:    cover property (pin_drive & tick);
  cov_dog_tick:     cover property (o_dog_tick & scaler_assign);

endmodule // tmz_timer0
`default_nettype wire

// ---- tmz_count_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// External count source model
// ****************************************
module tmz_count_src (
  // Clock
  input  wire logic i_clock,
  // Source level
  output var  logic o_level
);
  // Idle low; a burst only ever moves on the clock, so no glitch reaches the sampler
  initial begin
    o_level = 1'b0;
  end

  // Toggle the level tog times, holding each level h clocks (h of two or more keeps the minimum width)
  task automatic burst(input int tog, input int h);
    for (int i = 0; i < tog; i++) begin
      repeat (h) @(posedge i_clock);
      #1;
      o_level = ~o_level;
    end
  endtask
endmodule  // tmz_count_src
`default_nettype wire

// ---- test_tmz_timer0.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Bench for the timer with shared prescaler
// ****************************************
module test_tmz_timer0;
  logic        i_clock, i_rst, i_file_wr, i_option_wr, i_tris_wr;
  logic        i_dog_clear_instr, i_dog_overflow, i_port_bit;
  logic [4:0]  i_file_addr, i_file_rd_addr;
  logic [7:0]  i_file_wdata, i_option_data, o_file_rdata, m_exp;
  logic [5:0]  i_tris_data;
  logic        o_dog_tick, o_pin, o_pin_oe_n, pin_src, cmp_src, pin_wire;
  logic        chk_v, v_q, port_q, ov_q, dog_copy, clr_req;
  logic [31:0] rnd;
  int          n_mismatch, n_compared, cyc, m_sel;
  int          q_sel[$];
  logic [7:0]  q_exp[$];

  // Pad level: the block wins while it drives, otherwise the outside source
  assign pin_wire = (o_pin_oe_n === 1'b0) ? o_pin : pin_src;

  tmz_timer0 i_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_file_wr(i_file_wr), .i_file_addr(i_file_addr),
    .i_file_wdata(i_file_wdata), .i_file_rd_addr(i_file_rd_addr), .o_file_rdata(o_file_rdata),
    .i_option_wr(i_option_wr), .i_option_data(i_option_data), .i_tris_wr(i_tris_wr),
    .i_tris_data(i_tris_data), .i_dog_clear_instr(i_dog_clear_instr), .i_dog_overflow(i_dog_overflow),
    .o_dog_tick(o_dog_tick), .i_cmp_out(cmp_src), .i_ext_count_pin(pin_wire), .i_port_bit(i_port_bit),
    .o_ext_count_pin(o_pin), .o_ext_count_pin_oe_n(o_pin_oe_n)
  );
  tmz_count_src u_pin (.i_clock(i_clock), .o_level(pin_src));
  tmz_count_src u_cmp (.i_clock(i_clock), .o_level(cmp_src));

  // ****************************************
  // Clock, random background, watchdog
  // ****************************************
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Random watchdog traffic must never disturb the timer path
  always @(posedge i_clock) begin
    #1;
    rnd = xs(rnd);
    i_dog_overflow = rnd[3];
    i_dog_clear_instr = rnd[9] | clr_req;
    i_port_bit = rnd[17];
  end

  // ****************************************
  // Drivers
  // ****************************************
  task automatic pwr(input int kind, input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    i_file_addr = a;
    i_file_wdata = d;
    i_option_data = d;
    i_tris_data = d[5:0];
    i_file_wr = (kind == 0);
    i_option_wr = (kind == 1);
    i_tris_wr = (kind == 2);
    @(posedge i_clock);
    #1;
    {i_file_wr, i_option_wr, i_tris_wr} = 3'b000;
  endtask

  // Note an expectation; sel 0 read data, 1 pin enable, 2 pin value
  task automatic chk(input int sel, input logic [4:0] a, input logic [7:0] e);
    @(posedge i_clock);
    #1;
    i_file_rd_addr = a;
    chk_v = 1'b1;
    q_sel.push_back(sel);
    q_exp.push_back(e);
    @(posedge i_clock);
    #1;
    chk_v = 1'b0;
  endtask

  task automatic idle(input int m);
    repeat (m) @(posedge i_clock);
  endtask

  // Watchdog clear held over one sampling edge, ahead of any reassignment
  task automatic dog_clr();
    clr_req = 1'b1;
    idle(2);
    clr_req = 1'b0;
  endtask

  task automatic reset_view();
    chk(0, 5'h01, 8'h00);
    chk(0, 5'h07, 8'h7F);
    chk(0, 5'h02, 8'h00);
    chk(1, 5'h00, 8'h01);
  endtask

  // Counter mode: configure, clear, send edges, look early and late
  task automatic ext(input logic [7:0] cw, ow, input int src, tog, input logic [7:0] e1, e2, input logic oe);
    dog_clr();
    pwr(0, 5'h01, 8'h00);
    pwr(0, 5'h07, cw);
    pwr(1, 5'h00, ow);
    chk(1, 5'h00, {7'h00, oe});
    pwr(0, 5'h01, 8'h00);
    idle(12);
    if (src == 0) u_pin.burst(tog, 6);
    else u_cmp.burst(tog, 6);
    chk(0, 5'h01, e1);
    idle(4);
    chk(0, 5'h01, e2);
    if (src == 0) u_pin.burst(tog % 2, 6);
    else u_cmp.burst(tog % 2, 6);
  endtask

  // ****************************************
  // Monitor and report
  // ****************************************
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  always @(posedge i_clock) begin
    v_q <= chk_v;
    port_q <= i_port_bit;
    ov_q <= i_dog_overflow;
  end

  // Compare half a cycle after the edge, when registered outputs have settled
  always @(negedge i_clock) begin
    if (dog_copy) check("dog tick", {7'h00, ov_q}, {7'h00, o_dog_tick});
    if (v_q && q_sel.size() > 0) begin
      m_sel = q_sel.pop_front();
      m_exp = q_exp.pop_front();
      if (m_sel == 0) check("read data", m_exp, o_file_rdata);
      else if (m_sel == 1) check("pin enable", m_exp, {7'h00, o_pin_oe_n});
      else check("pin value", {7'h00, port_q}, {7'h00, o_pin});
    end
  end

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the planned run
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    {i_file_wr, i_option_wr, i_tris_wr, i_dog_clear_instr, i_dog_overflow, i_port_bit} = 6'h00;
    {i_file_addr, i_file_rd_addr, i_file_wdata, i_option_data, i_tris_data} = 32'h00000000;
    {chk_v, dog_copy, clr_req, n_mismatch, n_compared, cyc} = '0;
    rnd = 32'h74056C53;
    i_rst = 1'b1;
    idle(2);
    #1;
    i_rst = 1'b0;
    reset_view();
    pwr(0, 5'h07, 8'hD5);
    chk(0, 5'h08, 8'h55);
    pwr(1, 5'h00, 8'h08);
    pwr(0, 5'h01, 8'hFE);
    chk(0, 5'h01, 8'hFE);
    idle(17);
    chk(0, 5'h01, 8'h01);
    pwr(2, 5'h00, 8'h3B);
    chk(1, 5'h00, 8'h00);
    chk(2, 5'h00, 8'h00);
    dog_clr();
    // Each ratio: wait half a step past one scaled increment
    for (int n = 0; n < 8; n++) begin
      pwr(1, 5'h00, 8'(n));
      d = rnd[31:24];
      pwr(0, 5'h01, d);
      dog_copy = 1'b1;
      idle(4 * (2 + 3 * (1 << n)) - 1);
      chk(0, 5'h01, d + 8'h01);
      dog_copy = 1'b0;
    end
    dog_copy = 1'b1;
    ext(8'h7F, 8'h28, 0, 7, 8'h03, 8'h04, 1'b1);
    ext(8'h7F, 8'h38, 0, 7, 8'h03, 8'h03, 1'b1);
    ext(8'h6F, 8'h28, 1, 7, 8'h03, 8'h04, 1'b1);
    ext(8'h0F, 8'h38, 1, 7, 8'h03, 8'h04, 1'b1);
    ext(8'h3F, 8'h28, 1, 7, 8'h03, 8'h04, 1'b0);
    ext(8'h7F, 8'h20, 0, 8, 8'h02, 8'h02, 1'b1);
    dog_copy = 1'b0;
    @(posedge i_clock);
    #1;
    i_rst = 1'b1;
    idle(2);
    #1;
    i_rst = 1'b0;
    reset_view();
    idle(2);
    conclude();
  end
endmodule  // test_tmz_timer0
`default_nettype wire
